// ===== src/rcod_pkg.sv
// package of constants for the reference clock output divider
package rcod_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam int          AXI_ADDR_W     = 4;        // byte address width of the slave
   localparam int          AXI_DATA_W     = 32;       // bus data width
   localparam logic [3:0]  CTRL_OFFSET    = 4'h0;     // reference_clock_control byte address
   localparam int          CTRL_W         = 8;        // implemented register width

   // ************************************************************
   // reference_clock_control field layout
   // ************************************************************
   localparam int          EN_BIT         = 7;        // refclk_module_enable
   localparam int          DUTY_LSB       = 3;        // refclk_duty_select low bit
   localparam int          DUTY_W         = 2;        // refclk_duty_select width
   localparam int          DIV_LSB        = 0;        // refclk_divider_select low bit
   localparam int          DIV_W          = 3;        // refclk_divider_select width
   localparam logic [7:0]  CTRL_RESET     = 8'h10;    // duty msb set, all else clear
   localparam logic [7:0]  CTRL_WR_MASK   = 8'h9f;    // bits 6..5 unimplemented

   // ************************************************************
   // encodings
   // ************************************************************
   localparam logic [1:0]  DUTY_0         = 2'h0;     // output held low
   localparam logic [1:0]  DUTY_25        = 2'h1;     // quarter period high
   localparam logic [1:0]  DUTY_50        = 2'h2;     // half period high
   localparam logic [1:0]  DUTY_75        = 2'h3;     // three quarters high
   localparam logic [2:0]  DIV_BASE       = 3'h0;     // undivided system clock
   localparam logic [1:0]  RESP_OKAY      = 2'h0;     // axi okay
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;     // axi slave error, unmapped address

   // ************************************************************
   // generator states, one-hot
   // ************************************************************
   typedef enum logic [2:0] {
      RCOD_OFF  = 3'b001,                             // disabled, counter parked
      RCOD_BASE = 3'b010,                             // undivided, follows clock
      RCOD_DIV  = 3'b100                              // divided and shaped
   } rcod_state_t;

endpackage

// ===== src/rcod_wave_gen.sv
// divide counter and duty shaper that drive the reference clock outputs
`timescale 1ns/1ns
`default_nettype none
module rcod_wave_gen #(
   parameter int DIV_SEL_W = 3                          // width of divider code
) (
   input  wire logic                          aclk,       // system clock, sole source
   input  wire logic                          aresetn,    // sync reset, active low
   input  wire logic                          enable,     // module enable level
   input  wire logic                          sleep,      // clock stopped, hold state
   input  wire logic [rcod_pkg::DIV_W-1:0]    div_sel,    // divider code
   input  wire logic [rcod_pkg::DUTY_W-1:0]   duty_sel,   // duty code
   output logic                               ref_out,    // pin copy of reference
   output logic                               periph_out, // copy for on-chip users
   output logic [6:0]                         count       // divide counter, for checks
);
   import rcod_pkg::*;

   // ************************************************************
   // elaboration check
   // ************************************************************
   if (DIV_SEL_W != DIV_W) begin : g_bad_width
      $error("rcod_wave_gen: divider code width must be 3");
   end

   rcod_state_t state;                                  // current mode
   rcod_state_t next_state;                             // mode for next edge
   logic [6:0]  next_count;                             // next counter value
   logic        next_out;                               // next output level
   logic [7:0]  divisor;                                // 1 .. 128
   logic [7:0]  high_time;                              // cycles high per period
   logic [6:0]  last_count;                             // terminal count

   // ************************************************************
   // period and high time from the codes
   // ************************************************************
   // a divisor of two cannot show a quarter, so any nonzero duty gets at least one cycle
   always_comb begin
      divisor    = 8'h01 << div_sel;
      last_count = 7'(divisor - 8'h01);
      case (duty_sel)
         DUTY_25: high_time = divisor >> 2;
         DUTY_50: high_time = divisor >> 1;
         DUTY_75: high_time = (divisor >> 1) + (divisor >> 2);
         default: high_time = 8'h00;
      endcase
      if (duty_sel != DUTY_0 && high_time == 8'h00) begin
         high_time = 8'h01;                             // shortest visible pulse
      end
   end

   // ************************************************************
   // next state, counter and output
   // ************************************************************
   always_comb begin
      next_state = state;
      next_count = count;
      next_out   = ref_out;
      if (sleep) begin
         // clock stopped: everything keeps its level
         next_state = state;
      end else if (!enable) begin
         next_state = RCOD_OFF;
      end else if (div_sel == DIV_BASE) begin
         next_state = RCOD_BASE;
      end else begin
         next_state = RCOD_DIV;
      end
      if (!sleep) begin
         case (next_state)
            RCOD_OFF: begin
               // parked at the period start so the next enable is clean
               next_count = 7'h00;
               next_out   = 1'b0;
            end
            RCOD_BASE: begin
               // toggles on every edge, duty code has no effect here
               next_count = 7'h00;
               next_out   = ~ref_out;
            end
            RCOD_DIV: begin
               // a live code change may cut a period short, accepted as is
               next_out   = ({1'b0, count} < high_time);
               next_count = (count >= last_count) ? 7'h00 : 7'(count + 7'h01);
            end
            default: begin
               next_count = 7'h00;
               next_out   = 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // registers, clocked only by the system clock
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state      <= RCOD_OFF;
         count      <= 7'h00;
         ref_out    <= 1'b0;
         periph_out <= 1'b0;
      end else begin
         state      <= next_state;
         count      <= next_count;
         ref_out    <= next_out;
         periph_out <= next_out;
      end
   end

endmodule
`default_nettype wire

// ===== src/rcod_top.sv
// reference clock output divider with its axi4-lite control register
// Operation
// - output derived only from system clock
// - enable starts output glitch free
// - clearing enable stops output immediately
// - divider code selects divide by 1..128
// - divider field bits 2..0, reset zero
// - duty code selects 0/25/50/75 percent
// - undivided setting ignores duty code
// - duty field resets to 50 percent
// - live field writes apply while running
// - sleep freezes outputs at current level
// - enable bit 7, reset zero
// - bits 6..5 read zero, ignore writes
// - reference also feeds on-chip peripherals
`timescale 1ns/1ns
`default_nettype none
module rcod_top (
   input  wire logic                              aclk,          // system clock
   input  wire logic                              aresetn,       // sync reset, active low
   input  wire logic [rcod_pkg::AXI_ADDR_W-1:0]   s_axi_awaddr,  // write address
   input  wire logic                              s_axi_awvalid, // write address valid
   output logic                                   s_axi_awready, // write address ready
   input  wire logic [rcod_pkg::AXI_DATA_W-1:0]   s_axi_wdata,   // write data
   input  wire logic [3:0]                        s_axi_wstrb,   // write byte enables
   input  wire logic                              s_axi_wvalid,  // write data valid
   output logic                                   s_axi_wready,  // write data ready
   output logic [1:0]                             s_axi_bresp,   // write response
   output logic                                   s_axi_bvalid,  // write response valid
   input  wire logic                              s_axi_bready,  // write response ready
   input  wire logic [rcod_pkg::AXI_ADDR_W-1:0]   s_axi_araddr,  // read address
   input  wire logic                              s_axi_arvalid, // read address valid
   output logic                                   s_axi_arready, // read address ready
   output logic [rcod_pkg::AXI_DATA_W-1:0]        s_axi_rdata,   // read data
   output logic [1:0]                             s_axi_rresp,   // read response
   output logic                                   s_axi_rvalid,  // read data valid
   input  wire logic                              s_axi_rready,  // read data ready
   input  wire logic                              sleep,         // device asleep, clock stopped
   output logic                                   ref_clock_out_pin,     // reference to pin
   output logic                                   data_signal_modulator  // reference to modulator
);
   import rcod_pkg::*;

   // ************************************************************
   // control register and write channel state
   // ************************************************************
   logic [7:0]  ctrl;                                   // reference_clock_control
   logic [7:0]  next_ctrl;                              // next register value
   logic        aw_held;                                // write address captured
   logic        next_aw_held;
   logic        w_held;                                 // write data captured
   logic        next_w_held;
   logic [3:0]  aw_addr_q;                              // captured write address
   logic [3:0]  next_aw_addr_q;
   logic [7:0]  wdata_q;                                // captured low data byte
   logic [7:0]  next_wdata_q;
   logic        wstrb0_q;                               // captured low byte enable
   logic        next_wstrb0_q;
   logic        next_awready;
   logic        next_wready;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        wr_do;                                  // both halves present, commit
   logic        aw_take;                                // address handshake this edge
   logic        w_take;                                 // data handshake this edge

   // ************************************************************
   // write path: address and data in either order, then response
   // ************************************************************
   always_comb begin
      aw_take        = s_axi_awvalid && s_axi_awready;
      w_take         = s_axi_wvalid && s_axi_wready;
      next_aw_held   = aw_held || aw_take;
      next_w_held    = w_held || w_take;
      next_aw_addr_q = aw_take ? s_axi_awaddr : aw_addr_q;
      next_wdata_q   = w_take ? s_axi_wdata[7:0] : wdata_q;
      next_wstrb0_q  = w_take ? s_axi_wstrb[0] : wstrb0_q;
      wr_do          = aw_held && w_held && !s_axi_bvalid;
      next_ctrl      = ctrl;
      next_bvalid    = s_axi_bvalid;
      next_bresp     = s_axi_bresp;
      if (wr_do) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         if (aw_addr_q[3:2] == CTRL_OFFSET[3:2]) begin
            next_bresp = RESP_OKAY;
            // fields change even while running; glitches are the writer's risk
            if (wstrb0_q) begin
               next_ctrl = wdata_q & CTRL_WR_MASK;
            end
         end else begin
            next_bresp = RESP_SLVERR;                   // unmapped word
         end
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // one outstanding write: ready drops once its half is held
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl          <= CTRL_RESET;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr_q     <= 4'h0;
         wdata_q       <= 8'h00;
         wstrb0_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         ctrl          <= next_ctrl;
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         aw_addr_q     <= next_aw_addr_q;
         wdata_q       <= next_wdata_q;
         wstrb0_q      <= next_wstrb0_q;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
      end
   end

   // ************************************************************
   // read path: one read at a time, data registered
   // ************************************************************
   logic        next_arready;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   always_comb begin
      next_arready = s_axi_arready;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         if (s_axi_araddr[3:2] == CTRL_OFFSET[3:2]) begin
            // upper bits and unimplemented bits read as zero
            next_rdata = {24'h000000, ctrl & CTRL_WR_MASK};
            next_rresp = RESP_OKAY;
         end else begin
            next_rdata = 32'h00000000;
            next_rresp = RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end else if (!s_axi_rvalid) begin
         next_arready = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // ************************************************************
   // waveform generator
   // ************************************************************
   logic       gen_en;                                  // refclk_module_enable
   logic [2:0] gen_div;                                 // refclk_divider_select
   logic [1:0] gen_duty;                                // refclk_duty_select
   logic [6:0] gen_count;                               // divide counter

   assign gen_en   = ctrl[EN_BIT];
   assign gen_div  = ctrl[DIV_LSB +: DIV_W];
   assign gen_duty = ctrl[DUTY_LSB +: DUTY_W];

   rcod_wave_gen #(
      .DIV_SEL_W (DIV_W)
   ) u_wave (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (gen_en),
      .sleep      (sleep),
      .div_sel    (gen_div),
      .duty_sel   (gen_duty),
      .ref_out    (ref_clock_out_pin),
      .periph_out (data_signal_modulator),
      .count      (gen_count)
   );

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   reset_value_a: assert property (
      $rose(aresetn) |-> ctrl == CTRL_RESET)
      else $error("control register not at reset value");

   stop_now_a: assert property (
      !gen_en && !sleep |=> !ref_clock_out_pin)
      else $error("output not stopped after disable");

   park_count_a: assert property (
      !gen_en && !sleep |=> gen_count == 7'h00 ##1 gen_count == 7'h00 || gen_en)
      else $error("counter not parked while disabled");

   clean_start_a: assert property (
      $rose(gen_en) && gen_div == 3'h2 && gen_duty == DUTY_50 && !sleep
      ##1 !sleep && $stable(ctrl) ##1 !sleep && $stable(ctrl)
      |-> ref_clock_out_pin && $past(ref_clock_out_pin))
      else $error("first pulse after enable not full width");

   duty_zero_a: assert property (
      gen_en && gen_div != DIV_BASE && gen_duty == DUTY_0 && !sleep
      |=> !ref_clock_out_pin)
      else $error("zero duty output went high");

   base_toggle_a: assert property (
      gen_en && gen_div == DIV_BASE && !sleep
      |=> ref_clock_out_pin != $past(ref_clock_out_pin))
      else $error("undivided output did not follow clock");

   wrap_count_a: assert property (
      gen_en && !sleep && gen_div != DIV_BASE && $stable(ctrl)
      && {1'b0, gen_count} == 8'((8'h01 << gen_div) - 8'h01) |=> gen_count == 7'h00)
      else $error("divide counter did not wrap at divisor");

   sleep_hold_a: assert property (
      sleep |=> $stable(ref_clock_out_pin) && $stable(data_signal_modulator)
      && $stable(gen_count))
      else $error("outputs moved during sleep");

   twin_out_a: assert property (
      ref_clock_out_pin == data_signal_modulator)
      else $error("peripheral copy differs from pin");

   live_write_a: assert property (
      wr_do && aw_addr_q[3:2] == CTRL_OFFSET[3:2] && wstrb0_q
      |=> ctrl == ($past(wdata_q) & CTRL_WR_MASK))
      else $error("register write not applied");

   read_zero_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[6:5] == 2'h0 && s_axi_rdata[31:8] == 24'h000000)
      else $error("unimplemented bits read nonzero");

   // ************************************************************
   // bus handshake and waveform shape checks
   // ************************************************************
   // an answer that moves before it is taken is lost to a slow master
   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");

   rdata_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped before taken");

   // one write in flight: no new halves are taken while a response waits
   write_busy_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel ready while response pending");

   read_busy_a: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address ready while data pending");

   // a steady setting advances the counter by one up to the terminal count
   count_step_a: assert property (
      gen_en && !sleep && gen_div != DIV_BASE && $stable(ctrl)
      && {1'b0, gen_count} < 8'((8'h01 << gen_div) - 8'h01)
      |=> gen_count == 7'($past(gen_count) + 7'h01))
      else $error("divide counter did not advance");

   first_high_a: assert property (
      gen_en && !sleep && gen_div != DIV_BASE && gen_duty != DUTY_0
      && gen_count == 7'h00 |=> ref_clock_out_pin)
      else $error("period did not start high");

   half_low_a: assert property (
      gen_en && !sleep && gen_div != DIV_BASE && gen_duty == DUTY_50
      && {1'b0, gen_count} == ((8'h01 << gen_div) >> 1) |=> !ref_clock_out_pin)
      else $error("half duty high time too long");

   quarter_low_a: assert property (
      gen_en && !sleep && gen_div > 3'h1 && gen_duty == DUTY_25
      && {1'b0, gen_count} == ((8'h01 << gen_div) >> 2) |=> !ref_clock_out_pin)
      else $error("quarter duty high time too long");

endmodule
`default_nettype wire

// ===== verification/rcod_refclk_sink.sv
// consumer model that measures the reference clock it receives
`timescale 1ns/1ns
`default_nettype none
module rcod_refclk_sink (
   input  wire logic       aclk,    // system clock
   input  wire logic       refclk,  // reference from the pin
   output logic [7:0]      hi_len,  // high cycles of last full period
   output logic [7:0]      per_len  // length of last full period
);
   logic       prev = 1'b0;         // last sample, finds rising edges
   logic [7:0] run  = 8'h0;         // cycles since the last rise
   logic [7:0] hi   = 8'h0;         // high cycles since the last rise
   // a rise closes one period; the first result after enable is junk
   always_ff @(posedge aclk) begin
      prev <= refclk;
      if (refclk && !prev) begin
         per_len <= run;
         hi_len  <= hi;
         run     <= 8'h1;
         hi      <= 8'h1;
      end else begin
         run <= run + 8'h1;
         hi  <= hi + {7'h0, refclk};
      end
   end
endmodule
`default_nettype wire

// ===== verification/rcod_top_tb.sv
// self-checking bench for the reference clock output divider
`timescale 1ns/1ns
`default_nettype none
module rcod_top_tb;
   import rcod_pkg::*;
   logic        aclk    = 1'b0;    // 100 mhz system clock
   logic        aresetn = 1'b0;    // reset, active low
   logic [3:0]  awaddr  = 4'h0;    // write address
   logic [3:0]  araddr  = 4'h0;    // read address
   logic [31:0] wdata   = 32'h0;   // write data
   logic [3:0]  wstrb   = 4'h0;    // byte enables
   logic        awvalid = 1'b0;    // master valids and readies
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        sleep   = 1'b0;    // stopped clock stand-in
   wire logic   awready, wready, bvalid, arready, rvalid, pin, periph;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [7:0]  hi_len, per_len;
   logic [1:0]  resp;              // last response taken
   logic [31:0] rd;                // last read data taken
   int          n_fail = 0;
   int          num_checks = 0;
   always #5 aclk = ~aclk;
   rcod_top i_rcod_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sleep(sleep), .ref_clock_out_pin(pin),
      .data_signal_modulator(periph));
   rcod_refclk_sink i_rcod_refclk_sink (.aclk(aclk), .refclk(pin), .hi_len(hi_len),
      .per_len(per_len));
   // ************************************************************
   // reporting
   // ************************************************************
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_up(input string what);
      n_fail++;
      $display("[FAIL] %s expected answer seen timeout", what);
      finish_test();
   endtask
   // ************************************************************
   // bus cycles; readies are held up so answers are taken at once
   // ************************************************************
   task automatic bus_write(input logic [3:0] a, input logic [31:0] d,
                            input logic [3:0] s = 4'h1);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 50) give_up("bvalid");
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic bus_read(input logic [3:0] a);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 50) give_up("rvalid");
      resp = rresp;
      rd = rdata;
      rready <= 1'b0;
   endtask
   // high samples over a span, outputs looked at between edges
   task automatic count_high(input int span, output int hits);
      hits = 0;
      repeat (span) begin
         @(negedge aclk);
         check("periph copy", 32'(pin), 32'(periph));
         hits += int'(pin === 1'b1);
      end
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_regs;
      bus_read(CTRL_OFFSET);
      check("ctrl reset", 32'h10, rd);
      check("ctrl rresp", 32'(RESP_OKAY), 32'(resp));
      check("pin idle", 32'h0, 32'(pin));
      bus_write(CTRL_OFFSET, 32'h6f);
      check("ctrl bresp", 32'(RESP_OKAY), 32'(resp));
      bus_read(CTRL_OFFSET);
      check("reserved bits", 32'h0f, rd);
      // low byte strobe off: answered okay, register untouched
      bus_write(CTRL_OFFSET, 32'h9d, 4'h0);
      check("no strobe bresp", 32'(RESP_OKAY), 32'(resp));
      bus_read(CTRL_OFFSET);
      check("no strobe kept", 32'h0f, rd);
      bus_write(4'h4, 32'h1);
      check("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
      bus_read(4'h8);
      check("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
      check("unmapped rdata", 32'h0, rd);
   endtask
   task automatic t_divide;
      int h;
      int k;
      for (int d = 1; d < 8; d++) begin
         bus_write(CTRL_OFFSET, 32'h10);
         bus_write(CTRL_OFFSET, 32'h90 | d);
         for (k = 0; k < 300 && pin !== 1'b1; k++) @(negedge aclk);
         count_high(1, h);
         for (h = 0; pin === 1'b1 && h < 300; h++) @(negedge aclk);
         check("first pulse", 32'((1 << d) / 2) - 32'h1, 32'(h));
         repeat (3 << d) @(negedge aclk);
         check("period", 32'(1 << d), 32'(per_len));
         check("high time", 32'((1 << d) / 2), 32'(hi_len));
      end
   endtask
   task automatic t_duty;
      int h;
      for (int dc = 0; dc < 4; dc++) begin
         bus_write(CTRL_OFFSET, 32'h10);
         bus_write(CTRL_OFFSET, 32'h82 | (dc << 3));
         count_high(8, h);
         check("duty highs", 32'(2 * dc), 32'(h));
      end
      bus_write(CTRL_OFFSET, 32'h10);
      bus_write(CTRL_OFFSET, 32'h98);
      count_high(8, h);
      check("base follows clock", 32'h4, 32'(h));
   endtask
   task automatic t_live_stop;
      int h;
      bus_write(CTRL_OFFSET, 32'h92);
      bus_write(CTRL_OFFSET, 32'h94);
      repeat (48) @(negedge aclk);
      check("live divider", 32'h10, 32'(per_len));
      bus_write(CTRL_OFFSET, 32'h14);
      count_high(20, h);
      check("stopped low", 32'h0, 32'(h));
   endtask
   task automatic t_sleep;
      logic lvl;
      int h;
      bus_write(CTRL_OFFSET, 32'h93);
      repeat (5) @(negedge aclk);
      @(posedge aclk);
      sleep <= 1'b1;
      repeat (2) @(negedge aclk);
      lvl = pin;
      count_high(16, h);
      check("frozen level", 32'(lvl) * 32'd16, 32'(h));
      @(posedge aclk);
      sleep <= 1'b0;
   endtask
   // reset again while running: register and pin return to idle
   task automatic t_reset;
      bus_write(CTRL_OFFSET, 32'h9d);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      bus_read(CTRL_OFFSET);
      check("ctrl after reset", 32'h10, rd);
      check("pin after reset", 32'h0, 32'(pin));
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_divide();
      t_duty();
      t_live_stop();
      t_sleep();
      t_reset();
      finish_test();
   end
   initial begin
      repeat (90000) @(posedge aclk);
      give_up("run");
   end
endmodule
`default_nettype wire
